// *** logic/jia_top.sv ***
// Purpose: JTAG TAP with indirect data register giving access to Flash interface registers
// Assumes: tck runs while rst_b is low so the link side sees the reset
// Notes:   Launch word crosses by toggle handshake; it stays stable until the done toggle returns
`timescale 1ns/1ns

// Contract
// - Flash registers reachable as JTAG indirect registers
// - Opcode bits 19:18, payload bits 17:0
// - Opcode 0x poll, 10 read, 11 write
// - Poll captures but never updates
// - Read accepted after two shifted bits
// - Write transfers payload, targets up to 18 bits
// - Narrow write payload left-justified at bit 17
// - Outgoing word: zero, read data, busy
// - Busy set at start, cleared when finished
// - Read or write ignored while busy
// - Queued command launches when busy captured low
// - Read data right-justified above busy
// - Control register eight bits, reset zero
// - Write behaviour 001 programs then increments address
// - Behaviour 010 erases page on A5; 000 stores
module jia_top
  import jia_pkg::*;
#(
  parameter int ADDR_W  = 16,
  parameter int SCALE_W = 8
)
(
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              tck,
  input  wire logic              tms,
  input  wire logic              tdi,
  output logic                   tdo,
  output logic                   tdo_oe,
  output logic                   flash_req,
  output jia_fcmd_e              flash_cmd,
  output logic [ADDR_W-1:0]      flash_addr,
  output logic [BYTE_W-1:0]      flash_wdata,
  input  wire logic              flash_ack,
  input  wire logic [BYTE_W-1:0] flash_rdata,
  output logic                   scratchpad_select,
  output logic [SCALE_W-1:0]     flash_scale
);

  // ==========================================================
  // Elaboration checks
  initial
  begin
    if (ADDR_W < 1 || ADDR_W > PAY_W)
      $error("ADDR_W must be 1 to 18");
    if (SCALE_W < 1 || SCALE_W > PAY_W)
      $error("SCALE_W must be 1 to 18");
  end

  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, DR_SELECT, DR_CAPTURE, DR_SHIFT, DR_EXIT1, DR_PAUSE, DR_EXIT2,
    DR_UPDATE, IR_SELECT, IR_CAPT, IR_SHIFT, IR_EXIT1, IR_PAUSE, IR_EXIT2, IR_UPDATE
  } jia_tap_e;
  typedef enum logic [1:0] {FS_IDLE, FS_WAIT, FS_DONE} jia_fs_e;

  // ==========================================================
  // Link domain reset synchroniser
  logic tck_rst_s1_reg;
  logic tck_rst_b_reg;
  always_ff @(posedge tck)
  begin
    tck_rst_s1_reg <= rst_b;
    tck_rst_b_reg  <= tck_rst_s1_reg;
  end

  // ==========================================================
  // TAP controller
  jia_tap_e tap_reg;
  jia_tap_e tap_next;
  // Standard TMS-driven state walk
  always_comb
  begin
    tap_next = tap_reg;
    unique case (tap_reg)
      TAP_RESET:  tap_next = tms ? TAP_RESET : TAP_IDLE;
      TAP_IDLE:   tap_next = tms ? DR_SELECT : TAP_IDLE;
      DR_SELECT:  tap_next = tms ? IR_SELECT : DR_CAPTURE;
      DR_CAPTURE: tap_next = tms ? DR_EXIT1  : DR_SHIFT;
      DR_SHIFT:   tap_next = tms ? DR_EXIT1  : DR_SHIFT;
      DR_EXIT1:   tap_next = tms ? DR_UPDATE : DR_PAUSE;
      DR_PAUSE:   tap_next = tms ? DR_EXIT2  : DR_PAUSE;
      DR_EXIT2:   tap_next = tms ? DR_UPDATE : DR_SHIFT;
      DR_UPDATE:  tap_next = tms ? DR_SELECT : TAP_IDLE;
      IR_SELECT:  tap_next = tms ? TAP_RESET : IR_CAPT;
      IR_CAPT:    tap_next = tms ? IR_EXIT1  : IR_SHIFT;
      IR_SHIFT:   tap_next = tms ? IR_EXIT1  : IR_SHIFT;
      IR_EXIT1:   tap_next = tms ? IR_UPDATE : IR_PAUSE;
      IR_PAUSE:   tap_next = tms ? IR_EXIT2  : IR_PAUSE;
      IR_EXIT2:   tap_next = tms ? IR_UPDATE : IR_SHIFT;
      IR_UPDATE:  tap_next = tms ? DR_SELECT : TAP_IDLE;
    endcase
  end
  always_ff @(posedge tck)
  begin
    if (!tck_rst_b_reg)
      tap_reg <= TAP_RESET;
    else
      tap_reg <= tap_next;
  end

  // ==========================================================
  // Instruction register and target decode
  logic [IR_W-1:0] ir_shift_reg;
  logic [IR_W-1:0] ir_reg;
  logic            ind_sel;
  jia_tgt_e        sel_target;
  always_ff @(posedge tck)
  begin
    if (!tck_rst_b_reg || tap_reg == TAP_RESET)
    begin
      ir_shift_reg <= IR_RESET;
      ir_reg       <= IR_RESET;
    end
    else
    begin
      if (tap_reg == IR_CAPT)
        ir_shift_reg <= IR_CAPTURE;
      else if (tap_reg == IR_SHIFT)
        ir_shift_reg <= {tdi, ir_shift_reg[IR_W-1:1]};
      if (tap_reg == IR_UPDATE)
        ir_reg <= ir_shift_reg;
    end
  end

  // Map select codes onto indirect targets
  always_comb
  begin
    ind_sel    = 1'b1;
    sel_target = TGT_CTRL;
    unique case (ir_reg)
      IR_SEL_CTRL:  sel_target = TGT_CTRL;
      IR_SEL_DATA:  sel_target = TGT_DATA;
      IR_SEL_ADDR:  sel_target = TGT_ADDR;
      IR_SEL_SCALE: sel_target = TGT_SCALE;
      default:      ind_sel    = 1'b0;
    endcase
  end

  // ==========================================================
  // Indirect data register, bypass and launch
  logic [DR_W-1:0]  dr_shift_reg;
  logic             bypass_reg;
  logic             cap_busy_reg;
  logic             busy;
  logic             req_tgl_reg;
  jia_op_s          op_reg;
  logic [PAY_W-1:0] rd_link_reg;
  logic [1:0]       opcode;
  logic             launch;
  assign opcode = dr_shift_reg[OP_HI:OP_LO];
  // Launch on update of read/write only if busy was captured low
  assign launch = ind_sel && tap_reg == DR_UPDATE && opcode[1] && !cap_busy_reg;
  always_ff @(posedge tck)
  begin
    if (!tck_rst_b_reg)
    begin
      dr_shift_reg <= '0;
      bypass_reg   <= 1'b0;
      cap_busy_reg <= 1'b1;
    end
    else if (tap_reg == DR_CAPTURE)
    begin
      dr_shift_reg <= {1'b0, rd_link_reg, busy};
      cap_busy_reg <= busy;
      bypass_reg   <= 1'b0;
    end
    else if (tap_reg == DR_SHIFT)
    begin
      // New bits enter at bit 19 so a short shift fills the top
      dr_shift_reg <= {tdi, dr_shift_reg[DR_W-1:1]};
      bypass_reg   <= tdi;
    end
  end

  // Launch word held stable for the Flash side
  always_ff @(posedge tck)
  begin
    if (!tck_rst_b_reg)
    begin
      req_tgl_reg <= 1'b0;
      op_reg      <= '0;
    end
    else if (launch)
    begin
      req_tgl_reg    <= ~req_tgl_reg;
      op_reg.target  <= sel_target;
      op_reg.write   <= opcode == OPC_WRITE;
      op_reg.payload <= dr_shift_reg[PAY_HI:0];
    end
  end

  // Serial output on falling tck
  always_ff @(negedge tck)
  begin
    if (!tck_rst_b_reg)
    begin
      tdo    <= 1'b0;
      tdo_oe <= 1'b0;
    end
    else
    begin
      tdo_oe <= tap_reg == DR_SHIFT || tap_reg == IR_SHIFT;
      if (tap_reg == IR_SHIFT)
        tdo <= ir_shift_reg[0];
      else if (ind_sel)
        tdo <= dr_shift_reg[BUSY_POS];
      else
        tdo <= bypass_reg;
    end
  end

  // ==========================================================
  // Done return into link domain
  logic [2:0]       done_sync_reg;
  logic             done_tgl_reg;
  logic [PAY_W-1:0] result_reg;
  always_ff @(posedge tck)
  begin
    if (!tck_rst_b_reg)
    begin
      done_sync_reg <= '0;
      rd_link_reg   <= '0;
    end
    else
    begin
      done_sync_reg <= {done_sync_reg[1:0], done_tgl_reg};
      // Result is stable in the Flash domain once done has toggled
      if (done_sync_reg[1] != done_sync_reg[2])
        rd_link_reg <= result_reg;
    end
  end
  // Busy from launch until the done toggle has arrived and been taken
  assign busy = req_tgl_reg != done_sync_reg[2];

  // ==========================================================
  // Request into Flash domain
  logic [2:0] req_sync_reg;
  logic       req_edge;
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      req_sync_reg <= '0;
    else
      req_sync_reg <= {req_sync_reg[1:0], req_tgl_reg};
  end
  assign req_edge = req_sync_reg[1] != req_sync_reg[2];

  // ==========================================================
  // Flash interface registers and operation sequencer
  logic [7:0]         ctrl_reg;
  logic [BYTE_W-1:0]  data_reg;
  logic [ADDR_W-1:0]  addr_reg;
  logic [SCALE_W-1:0] scale_reg;
  jia_fs_e            fs_reg;
  logic [2:0]         wr_beh;
  logic [3:0]         rd_beh;
  logic [BYTE_W-1:0]  wr_byte;
  assign wr_beh  = ctrl_reg[CTRL_WR_HI:CTRL_WR_LO];
  assign rd_beh  = ctrl_reg[CTRL_RD_HI:CTRL_RD_LO];
  assign wr_byte = op_reg.payload[PAY_HI -: BYTE_W];

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      ctrl_reg     <= CTRL_RESET;
      data_reg     <= DATA_RESET;
      addr_reg     <= '0;
      scale_reg    <= '0;
      result_reg   <= '0;
      done_tgl_reg <= 1'b0;
      flash_req    <= 1'b0;
      flash_cmd    <= FCMD_READ;
      fs_reg       <= FS_IDLE;
    end
    else
    begin
      unique case (fs_reg)
        FS_IDLE:
        begin
          if (req_edge)
          begin
            fs_reg <= FS_DONE;
            if (op_reg.write)
            begin
              unique case (op_reg.target)
                TGT_CTRL:  ctrl_reg  <= wr_byte;
                TGT_ADDR:  addr_reg  <= op_reg.payload[PAY_HI -: ADDR_W];
                TGT_SCALE: scale_reg <= op_reg.payload[PAY_HI -: SCALE_W];
                TGT_DATA:
                begin
                  data_reg <= wr_byte;
                  if (wr_beh == WRB_PROGRAM)
                  begin
                    flash_req <= 1'b1;
                    flash_cmd <= FCMD_PROGRAM;
                    fs_reg    <= FS_WAIT;
                  end
                  else if (wr_beh == WRB_ERASE && wr_byte == ERASE_KEY)
                  begin
                    flash_req <= 1'b1;
                    flash_cmd <= FCMD_ERASE;
                    fs_reg    <= FS_WAIT;
                  end
                end
              endcase
            end
            else
            begin
              // Read results sit right-justified
              unique case (op_reg.target)
                TGT_CTRL:  result_reg <= PAY_W'(ctrl_reg);
                TGT_ADDR:  result_reg <= PAY_W'(addr_reg);
                TGT_SCALE: result_reg <= PAY_W'(scale_reg);
                TGT_DATA:
                begin
                  result_reg <= PAY_W'(data_reg);
                  if (rd_beh == RDB_FETCH)
                  begin
                    flash_req <= 1'b1;
                    flash_cmd <= FCMD_READ;
                    fs_reg    <= FS_WAIT;
                  end
                end
              endcase
            end
          end
        end
        FS_WAIT:
        begin
          if (flash_ack)
          begin
            flash_req <= 1'b0;
            fs_reg    <= FS_DONE;
            if (flash_cmd == FCMD_PROGRAM)
              addr_reg <= addr_reg + 1'b1;
            else if (flash_cmd == FCMD_READ)
            begin
              data_reg   <= flash_rdata;
              result_reg <= PAY_W'(flash_rdata);
            end
          end
        end
        FS_DONE:
        begin
          done_tgl_reg <= req_sync_reg[2];
          fs_reg       <= FS_IDLE;
        end
      endcase
    end
  end

  // Flash side outputs from registers
  assign flash_addr        = addr_reg;
  assign flash_wdata       = data_reg;
  assign scratchpad_select = ctrl_reg[CTRL_SCRATCH];
  assign flash_scale       = scale_reg;

endmodule

// *** inc/jia_pkg.sv ***
// Purpose: Shared constants and types for the JTAG indirect register access block
// Assumes: Command word of 20 bits, 16-bit instruction register
// Notes:   Address and scale target widths are module parameters; control and data registers are fixed at 8 bits
package jia_pkg;

  // ==========================================================
  // Instruction register
  localparam int          IR_W         = 16;
  localparam logic [15:0] IR_SEL_CTRL  = 16'h0082;
  localparam logic [15:0] IR_SEL_DATA  = 16'h0083;
  localparam logic [15:0] IR_SEL_ADDR  = 16'h0084;
  localparam logic [15:0] IR_SEL_SCALE = 16'h0085;
  localparam logic [15:0] IR_RESET     = 16'hFFFF;
  localparam logic [15:0] IR_CAPTURE   = 16'h0001;

  // ==========================================================
  // Indirect data register layout
  localparam int DR_W      = 20;
  localparam int PAY_W     = 18;
  localparam int OP_HI     = 19;
  localparam int OP_LO     = 18;
  localparam int PAY_HI    = 17;
  localparam int BUSY_POS  = 0;
  localparam int BYTE_W    = 8;
  localparam logic [1:0] OPC_READ  = 2'h2;
  localparam logic [1:0] OPC_WRITE = 2'h3;

  // ==========================================================
  // Flash interface control register
  localparam logic [7:0] CTRL_RESET   = 8'h00;
  localparam int         CTRL_SCRATCH = 7;
  localparam int         CTRL_WR_HI   = 6;
  localparam int         CTRL_WR_LO   = 4;
  localparam int         CTRL_RD_HI   = 3;
  localparam int         CTRL_RD_LO   = 0;
  localparam logic [2:0] WRB_STORE    = 3'h0;
  localparam logic [2:0] WRB_PROGRAM  = 3'h1;
  localparam logic [2:0] WRB_ERASE    = 3'h2;
  localparam logic [3:0] RDB_FETCH    = 4'h1;
  localparam logic [7:0] ERASE_KEY    = 8'hA5;
  localparam logic [7:0] DATA_RESET   = 8'h00;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {TGT_CTRL, TGT_DATA, TGT_ADDR, TGT_SCALE} jia_tgt_e;
  typedef enum logic [1:0] {FCMD_READ, FCMD_PROGRAM, FCMD_ERASE} jia_fcmd_e;

  typedef struct packed {
    jia_tgt_e          target;
    logic              write;
    logic [PAY_W-1:0]  payload;
  } jia_op_s;

endpackage

// *** tb/jia_monitor.sv ***
// Purpose: Port checker for the indirect access block
// Assumes: Flash request and acknowledge live in the clk domain
// Notes:   Bound onto every jia_top instance
`timescale 1ns/1ns
module jia_monitor
  import jia_pkg::*;
#(
  parameter int ADDR_W  = 16,
  parameter int SCALE_W = 8
)
(
  input wire logic              clk,
  input wire logic              rst_b,
  input wire logic              tck,
  input wire logic              tdo_oe,
  input wire logic              flash_req,
  input wire jia_fcmd_e         flash_cmd,
  input wire logic [ADDR_W-1:0] flash_addr,
  input wire logic [BYTE_W-1:0] flash_wdata,
  input wire logic              flash_ack
);
  // ==========================================================
  // Flash request handshake, reset and link output checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_req_until_ack: assert property (flash_req && !flash_ack |=> flash_req)
    else $error("request dropped early");
  a_req_ends_ack: assert property (flash_req && flash_ack |=> !flash_req)
    else $error("request held after ack");
  a_req_fields_stable: assert property (flash_req && !flash_ack |=>
    $stable(flash_cmd) && $stable(flash_wdata) && $stable(flash_addr)) else $error("request fields moved");
  a_program_steps_addr: assert property (flash_req && flash_ack && flash_cmd == FCMD_PROGRAM |=>
    flash_addr == $past(flash_addr) + 1'b1) else $error("address not stepped");
  a_erase_needs_key: assert property ($rose(flash_req) && flash_cmd == FCMD_ERASE |->
    flash_wdata == ERASE_KEY) else $error("erase without key");
  a_one_at_time: assert property ($fell(flash_req) |=> !flash_req [*8])
    else $error("request right after completion");
  a_reset_no_req: assert property (@(posedge clk) disable iff (1'b0) !rst_b |=> !flash_req)
    else $error("request in reset");
  a_link_reset_quiet: assert property (@(posedge tck) disable iff (1'b0) !rst_b [*5] |-> !tdo_oe)
    else $error("data out enabled in reset");
  // Main scenarios reached
  c_program: cover property (flash_ack && flash_cmd == FCMD_PROGRAM);
  c_read: cover property (flash_ack && flash_cmd == FCMD_READ);
  c_erase: cover property (flash_ack && flash_cmd == FCMD_ERASE);
endmodule

bind jia_top jia_monitor #(.ADDR_W(ADDR_W), .SCALE_W(SCALE_W)) u_monitor (.clk(clk), .rst_b(rst_b),
  .tck(tck), .tdo_oe(tdo_oe), .flash_req(flash_req), .flash_cmd(flash_cmd), .flash_addr(flash_addr),
  .flash_wdata(flash_wdata), .flash_ack(flash_ack));

// *** tb/jia_flash_model.sv ***
// Purpose: Behavioural Flash array on the block's request port
// Assumes: One request at a time, 256 bytes modelled
// Notes:   slow stretches the answer so busy shows on the link
`timescale 1ns/1ns
module jia_flash_model
  import jia_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              slow,
  input  wire logic              flash_req,
  input  wire jia_fcmd_e         flash_cmd,
  input  wire logic [15:0]       flash_addr,
  input  wire logic [BYTE_W-1:0] flash_wdata,
  output logic                   flash_ack,
  output logic [BYTE_W-1:0]      flash_rdata
);
  logic [BYTE_W-1:0] mem_reg [256];
  int                wait_reg;

  // ==========================================================
  // Delayed one-cycle answer; idle data bus toggles
  always @(posedge clk)
  begin
    flash_ack <= 1'b0;
    flash_rdata <= rst_b ? ~flash_rdata : 8'h00;
    if (!rst_b)
      wait_reg <= 0;
    else if (flash_req && !flash_ack)
    begin
      if (wait_reg < (slow ? 400 : 2))
        wait_reg <= wait_reg + 1;
      else
      begin
        wait_reg <= 0;
        flash_ack <= 1'b1;
        case (flash_cmd)
          FCMD_READ:    flash_rdata <= mem_reg[flash_addr[7:0]];
          FCMD_PROGRAM: mem_reg[flash_addr[7:0]] <= flash_wdata;
          default:      foreach (mem_reg[i]) mem_reg[i] <= 8'hFF;
        endcase
      end
    end
  end
endmodule

// *** tb/tb_top.sv ***
// Purpose: Self-checking bench on the JTAG link and Flash port
// Assumes: Scans start and end in Run-Test/Idle
// Notes:   Fixed seed; Flash model answers fast or slow
`timescale 1ns/1ns
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin err_total++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module tb_top;
  import jia_pkg::*;
  logic        clk = 1'b0, tck = 1'b0, rst_b = 1'b0, tms = 1'b1, tdi = 1'b0, slow = 1'b0;
  logic        tdo, tdo_oe, flash_req, flash_ack, scratchpad_select;
  jia_fcmd_e   flash_cmd;
  logic [15:0] flash_addr, a;
  logic [7:0]  flash_wdata, flash_rdata, flash_scale, v, d;
  logic [7:0]  shadow [256];
  logic [19:0] q;
  int          err_total = 0;
  int          comparisons = 0;
  int          acks = 0;
  int          n0;
  int          seed = 32'h1812b1bd;

  // ==========================================================
  // Clocks, acknowledge count, instances
  always #5 clk = ~clk;
  initial
  begin
    #7;
    forever #32 tck = ~tck;
  end
  always @(posedge clk) if (rst_b && flash_ack) acks++;
  jia_top #(.ADDR_W(16), .SCALE_W(8)) dut (.clk(clk), .rst_b(rst_b), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo(tdo), .tdo_oe(tdo_oe), .flash_req(flash_req), .flash_cmd(flash_cmd), .flash_addr(flash_addr),
    .flash_wdata(flash_wdata), .flash_ack(flash_ack), .flash_rdata(flash_rdata),
    .scratchpad_select(scratchpad_select), .flash_scale(flash_scale));
  jia_flash_model u_flash (.clk(clk), .rst_b(rst_b), .slow(slow), .flash_req(flash_req),
    .flash_cmd(flash_cmd), .flash_addr(flash_addr), .flash_wdata(flash_wdata), .flash_ack(flash_ack),
    .flash_rdata(flash_rdata));

  // ==========================================================
  // JTAG host tasks
  task automatic tick(input logic m, input logic b);
    @(negedge tck);
    tms <= m;
    tdi <= b;
    @(posedge tck);
  endtask
  task automatic scan(input logic ir, input int n, input logic [19:0] w);
    q = '0;
    tick(1'b1, 1'b0);
    if (ir)
      tick(1'b1, 1'b0);
    tick(1'b0, 1'b0);
    tick(1'b0, 1'b0);
    for (int i = 0; i < n; i++)
    begin
      tick(i == n - 1, w[20 - n + i]);
      q[i] = tdo;
    end
    `CHK("shift out enable", 1'b1, tdo_oe)
    tick(1'b1, 1'b0);
    tick(1'b0, 1'b0);
    `CHK("idle out enable", 1'b0, tdo_oe)
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 60; i++)
    begin
      scan(1'b0, 1, 20'h0);
      if (q[0] === 1'b0)
        return;
    end
    err_total++;
    $display("CHECK FAILED busy expected 0 seen 1");
    stop_test();
  endtask
  task automatic wr(input logic [15:0] sel, input int n, input logic [17:0] p);
    scan(1'b1, 16, {sel, 4'h0});
    scan(1'b0, n, {OPC_WRITE, p});
    wait_idle();
  endtask
  task automatic rd(input logic [15:0] sel);
    scan(1'b1, 16, {sel, 4'h0});
    scan(1'b0, 2, {OPC_READ, 18'h0});
    wait_idle();
    scan(1'b0, 9, 20'h0);
    v = q[8:1];
  endtask
  function automatic logic [15:0] next_addr(logic [15:0] cur, logic [7:0] ctrl);
    return (ctrl[6:4] == WRB_PROGRAM) ? cur + 16'h1 : cur;
  endfunction
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    repeat (10) @(posedge clk);
    repeat (6) @(posedge tck);
    @(negedge clk);
    rst_b = 1'b1;
    repeat (3) @(posedge tck);
    tick(1'b0, 1'b0);
    rd(IR_SEL_CTRL);
    `CHK("control reset", CTRL_RESET, v)
    for (int i = 0; i < 3; i++)
    begin
      d = $random(seed);
      wr(IR_SEL_CTRL, 10, {d, 10'h0});
      rd(IR_SEL_CTRL);
      `CHK("control readback", d, v)
      `CHK("scratchpad select", d[7], scratchpad_select)
    end
    a = $random(seed);
    d = $random(seed);
    wr(IR_SEL_ADDR, 18, {a, 2'h0});
    `CHK("address", a, flash_addr)
    wr(IR_SEL_SCALE, 10, {d, 10'h0});
    `CHK("scale", d, flash_scale)
    $display("test registers done");
    wr(IR_SEL_CTRL, 10, {8'h10, 10'h0});
    for (int i = 0; i < 4; i++)
    begin
      slow = i[0];
      d = $random(seed);
      shadow[8'(a + i)] = d;
      n0 = acks;
      wr(IR_SEL_DATA, 10, {d, 10'h0});
      `CHK("program count", n0 + 1, acks)
      `CHK("address step", next_addr(16'(a + i), 8'h10), flash_addr)
    end
    wr(IR_SEL_CTRL, 10, {8'h01, 10'h0});
    for (int i = 0; i < 4; i++)
    begin
      wr(IR_SEL_ADDR, 18, {16'(a + i), 2'h0});
      rd(IR_SEL_DATA);
      `CHK("fetched byte", shadow[8'(a + i)], v)
      `CHK("fetch keeps address", 16'(a + i), flash_addr)
    end
    $display("test program and fetch done");
    wr(IR_SEL_CTRL, 10, {8'h10, 10'h0});
    wr(IR_SEL_ADDR, 18, {a, 2'h0});
    slow = 1'b1;
    n0 = acks;
    d = $random(seed);
    scan(1'b1, 16, {IR_SEL_DATA, 4'h0});
    scan(1'b0, 10, {OPC_WRITE, 8'h5A, 10'h0});
    scan(1'b0, 1, 20'h0);
    `CHK("busy set", 1'b1, q[0])
    for (int i = 0; i < 60; i++)
    begin
      scan(1'b0, 10, {OPC_WRITE, d, 10'h0});
      if (q[0] === 1'b0)
        break;
    end
    `CHK("queued capture", 1'b0, q[0])
    wait_idle();
    slow = 1'b0;
    `CHK("queued launches once", n0 + 2, acks)
    `CHK("queued address", a + 16'h2, flash_addr)
    `CHK("queued data", d, flash_wdata)
    n0 = acks;
    v = flash_wdata;
    scan(1'b0, 20, {2'b01, 18'($random(seed))});
    `CHK("poll top bit", 1'b0, q[19])
    wait_idle();
    `CHK("poll no update", v, flash_wdata)
    `CHK("poll no request", n0, acks)
    $display("test busy and poll done");
    wr(IR_SEL_CTRL, 10, {8'h20, 10'h0});
    wr(IR_SEL_DATA, 10, {8'h5A, 10'h0});
    `CHK("no erase without key", n0, acks)
    wr(IR_SEL_DATA, 10, {ERASE_KEY, 10'h0});
    `CHK("erase runs", n0 + 1, acks)
    `CHK("erase keeps address", a + 16'h2, flash_addr)
    wr(IR_SEL_CTRL, 10, {8'h01, 10'h0});
    rd(IR_SEL_DATA);
    `CHK("erased byte", 8'hFF, v)
    d = $random(seed);
    wr(IR_SEL_CTRL, 10, {8'h00, 10'h0});
    wr(IR_SEL_DATA, 10, {d, 10'h0});
    rd(IR_SEL_DATA);
    `CHK("stored byte", d, v)
    `CHK("store no request", n0 + 2, acks)
    $display("test erase and store done");
    stop_test();
  end
endmodule
